// ===== tdcc_pkg.sv
// Purpose: Shared constants, register layout and carrier types of the converter control bank
// Assumes: 10 MHz system clock, AXI4-Lite register access with 32-bit data
// Notes: Settling counts round up to whole clock cycles
package tdcc_pkg;

  // System clock period and settling times of the fast oscillator
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned T_SETTLE_A_US = 480;
  localparam int unsigned T_SETTLE_B_US = 1460;
  localparam int unsigned T_SETTLE_C_US = 2440;
  localparam int unsigned T_SETTLE_D_US = 5140;

  // Least time, so round up
  function automatic int unsigned us_to_cycles(input int unsigned us);
    return (us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  localparam int unsigned SETTLE_A_CYC = us_to_cycles(T_SETTLE_A_US);
  localparam int unsigned SETTLE_B_CYC = us_to_cycles(T_SETTLE_B_US);
  localparam int unsigned SETTLE_C_CYC = us_to_cycles(T_SETTLE_C_US);
  localparam int unsigned SETTLE_D_CYC = us_to_cycles(T_SETTLE_D_US);
  localparam int unsigned SETTLE_CNT_W = 16;

  // Register map, byte addresses
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_COMMAND = 8'h0C;
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_CONFIG = 3'h1;
  localparam logic [2:0] SEL_STATUS = 3'h2;
  localparam logic [2:0] SEL_RESULT = 3'h3;
  localparam logic [2:0] SEL_COMMAND = 3'h4;

  // Serial opcodes accepted through the command register
  localparam logic [7:0] OPC_POWER_ON_RESET = 8'h50;
  localparam logic [7:0] OPC_INIT = 8'h70;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int unsigned PRECNT_W = 14;
  localparam logic [13:0] PRECNT_MAX = 14'h3FFF;
  localparam logic [31:0] ERR_VALUE = 32'hFFFFFFFF;

  // Fast oscillator start options
  localparam logic [2:0] START_OFF = 3'h0;
  localparam logic [2:0] START_ON = 3'h1;
  localparam logic [2:0] START_SETTLE_A = 3'h2;
  localparam logic [2:0] START_SETTLE_B = 3'h3;
  localparam logic [2:0] START_SETTLE_C = 3'h4;
  localparam logic [2:0] START_SETTLE_D = 3'h5;

  // Predivider codes
  localparam logic [1:0] DIV_BY_1 = 2'h0;
  localparam logic [1:0] DIV_BY_2 = 2'h1;
  localparam logic [1:0] DIV_BY_4 = 2'h2;

  typedef struct packed {
    logic [18:0] rsvd;
    logic measure_mode2;
    logic twofold_resolution_mode;
    logic fourfold_resolution_mode;
    logic timeout_error_value_enable;
    logic auto_reinit_enable;
    logic phase_noise_disable;
    logic start_noise_enable;
    logic osc32_low_current;
    logic [2:0] fast_osc_start_option;
    logic [1:0] fast_osc_predivider;
  } tdcc_cfg_t;

  localparam logic [31:0] CFG_WMASK = 32'h00001FFF;
  localparam logic [31:0] CFG_RESET = 32'h00000024;

  typedef struct packed {
    logic [23:0] rsvd;
    logic fast_osc_ready;
    logic tdc_timeout_flag;
    logic precounter_timeout_flag;
    logic sensor_open_flag;
    logic sensor_short_flag;
    logic nvm_corrected_flag;
    logic nvm_uncorrectable_flag;
    logic config_matches_nvm_flag;
  } tdcc_status_t;

  // Events from the measurement core, same clock
  typedef struct packed {
    logic nvm_single_err;
    logic nvm_double_err;
    logic sensor_short;
    logic sensor_open;
    logic tdc_overflow;
    logic meas_done;
    logic core_irq;
    logic meas_active;
    logic result_valid;
  } tdcc_evt_t;

  // Controls toward the measurement core
  typedef struct packed {
    logic fast_osc_enable;
    logic fast_osc_ready;
    logic fast_osc_tick;
    logic osc32_low_current;
    logic start_noise_enable;
    logic phase_noise_disable;
    logic twofold_resolution_mode;
    logic fourfold_resolution_mode;
    logic measure_mode2;
    logic init_pulse;
    logic por_pulse;
  } tdcc_ctrl_t;

  typedef enum logic [1:0] {
    OSC_ST_OFF = 2'b00,
    OSC_ST_SETTLE = 2'b01,
    OSC_ST_READY = 2'b10
  } tdcc_osc_state_t;

endpackage

// ===== tdcc_fast_osc.sv
// Purpose: Fast oscillator enable, settling wait and predivided tick
// Assumes: Oscillator pin is asynchronous and slower than half the system clock
// Notes: Tick is one system cycle wide per divided oscillator period
`timescale 1ns/1ps
module tdcc_fast_osc import tdcc_pkg::*; #(
  parameter int unsigned SETTLE_A = SETTLE_A_CYC,
  parameter int unsigned SETTLE_B = SETTLE_B_CYC,
  parameter int unsigned SETTLE_C = SETTLE_C_CYC,
  parameter int unsigned SETTLE_D = SETTLE_D_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic soft_rst,
  input wire logic fast_oscillator_clock,
  input wire logic [1:0] fast_osc_predivider,
  input wire logic [2:0] fast_osc_start_option,
  input wire logic run_req,
  output logic osc_enable,
  output logic osc_ready,
  output logic osc_tick
);

  function automatic logic [SETTLE_CNT_W-1:0] settle_limit(input logic [2:0] opt);
    case (opt)
      START_SETTLE_A: return SETTLE_CNT_W'(SETTLE_A);
      START_SETTLE_B: return SETTLE_CNT_W'(SETTLE_B);
      START_SETTLE_C: return SETTLE_CNT_W'(SETTLE_C);
      default: return SETTLE_CNT_W'(SETTLE_D);
    endcase
  endfunction

  tdcc_osc_state_t st_q, st_d;
  logic [SETTLE_CNT_W-1:0] cnt_q, cnt_d;
  logic [2:0] sync_q, sync_d;
  logic [1:0] div_q, div_d;
  logic tick_q, tick_d;
  logic want_on;
  logic edge_seen;

  // Oscillator runs when always on, or on demand for the settling options
  assign want_on = (fast_osc_start_option == START_ON) ||
                   ((fast_osc_start_option != START_OFF) && run_req);
  assign edge_seen = sync_q[1] & ~sync_q[2];

  // Next state: synchroniser, settling counter and predivider
  always_comb begin
    sync_d = {sync_q[1:0], fast_oscillator_clock};
    st_d = st_q;
    cnt_d = cnt_q;
    div_d = div_q;
    tick_d = 1'b0;
    case (st_q)
      OSC_ST_OFF: begin
        cnt_d = '0;
        if (want_on) begin
          st_d = (fast_osc_start_option == START_ON) ? OSC_ST_READY : OSC_ST_SETTLE;
        end
      end
      OSC_ST_SETTLE: begin
        cnt_d = cnt_q + 1'b1;
        if (!want_on) begin
          st_d = OSC_ST_OFF;
        end else if (cnt_q == settle_limit(fast_osc_start_option) - 1'b1) begin
          st_d = OSC_ST_READY; // RQ9
        end
      end
      OSC_ST_READY: begin
        if (!want_on) begin
          st_d = OSC_ST_OFF;
        end
      end
      default: st_d = OSC_ST_OFF;
    endcase
    // Divide by 1, 2 or 4 counted in oscillator edges
    if (edge_seen && (st_q == OSC_ST_READY)) begin
      div_d = div_q + 1'b1;
      case (fast_osc_predivider)
        DIV_BY_1: tick_d = 1'b1; // RQ8
        DIV_BY_2: tick_d = div_q[0]; // RQ8
        default: tick_d = div_q == 2'h3; // RQ8
      endcase
    end
    if (soft_rst) begin
      st_d = OSC_ST_OFF;
      cnt_d = '0;
      div_d = '0;
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= OSC_ST_OFF;
      cnt_q <= '0;
      sync_q <= '0;
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sync_q <= sync_d;
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  assign osc_enable = st_q != OSC_ST_OFF;
  assign osc_ready = st_q == OSC_ST_READY;
  assign osc_tick = tick_q;

  property p_settle_done;
    @(posedge clk_sys) disable iff (!rstn)
    (st_q == OSC_ST_SETTLE && want_on && !soft_rst &&
     cnt_q == settle_limit(fast_osc_start_option) - 1'b1) |=> osc_ready;
  endproperty
  a_settle_done: assert property (p_settle_done) else $error("settling end did not give ready"); // RQ9

  property p_div4_spacing;
    @(posedge clk_sys) disable iff (!rstn)
    (tick_q && fast_osc_predivider == DIV_BY_4 && $stable(fast_osc_predivider)) |=> !tick_q [*4];
  endproperty
  a_div4_spacing: assert property (p_div4_spacing) else $error("divide by four tick too close"); // RQ8

endmodule

// ===== tdcc_regs.sv
// Purpose: Configuration, status and command bank of the time-to-digital converter
// Assumes: AXI4-Lite master, core events on clk_sys, oscillator pin asynchronous
// Notes: Error flags are sticky until an init or power-on reset; set wins over the init clear
// Operation
// [RQ1] Status shows whether configuration equals the nonvolatile image.
// [RQ2] Flag uncorrectable memory error on multi-bit error.
// [RQ3] Flag corrected memory error on repaired single-bit error.
// [RQ4] Flag shorted temperature sensor.
// [RQ5] Flag open temperature sensor.
// [RQ6] Mode two: flag overflow of the 14-bit precounter.
// [RQ7] Flag converter overflow before the measurement completes.
// [RQ8] Predivider code 0 passes, 1 halves, 2 quarters the fast clock.
// [RQ9] Fast oscillator off, on, or on with 480us/1.46/2.44/5.14ms settling.
// [RQ10] Current option bit for the 32 kHz oscillator.
// [RQ11] Start noise enable injects extra noise on the start channel.
// [RQ12] Disable bit turns off the phase noise generator.
// [RQ13] Auto re-init runs an init after every interrupt.
// [RQ14] With error value on, a timeout writes all ones as result.
// [RQ15] Fourfold resolution, only in measurement mode two.
// [RQ16] Twofold resolution in both measurement modes.
// [RQ17] Host does power-on reset, configuration write, then init.
// [RQ18] Status register readable at any time, all flags in one word.
// [RQ19] Opcode 0x50 resets the whole device including configuration.
// [RQ20] Opcode 0x70 prepares a measurement, configuration kept.
`timescale 1ns/1ps
module tdcc_regs import tdcc_pkg::*; #(
  parameter int unsigned SETTLE_A = SETTLE_A_CYC,
  parameter int unsigned SETTLE_B = SETTLE_B_CYC,
  parameter int unsigned SETTLE_C = SETTLE_C_CYC,
  parameter int unsigned SETTLE_D = SETTLE_D_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fast_oscillator_clock,
  input wire tdcc_evt_t core_evt,
  input wire logic [31:0] core_result,
  input wire logic [31:0] nvm_config,
  output tdcc_ctrl_t core_ctrl
);

  // Address decode shared by the read and write paths
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    case (addr)
      OFS_CONFIG: return SEL_CONFIG;
      OFS_STATUS: return SEL_STATUS;
      OFS_RESULT: return SEL_RESULT;
      OFS_COMMAND: return SEL_COMMAND;
      default: return SEL_NONE;
    endcase
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic aw_vld_q, aw_vld_d, w_vld_q, w_vld_d, b_vld_q, b_vld_d, r_vld_q, r_vld_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d, r_data_q, r_data_d, result_q, result_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic [1:0] b_resp_q, b_resp_d, r_resp_q, r_resp_d;
  tdcc_cfg_t cfg_q, cfg_d;
  tdcc_status_t stat_q, stat_d;
  tdcc_ctrl_t ctrl_q, ctrl_d;
  logic [PRECNT_W-1:0] precnt_q, precnt_d;
  logic init_q, init_d, por_q, por_d, run_q, run_d;
  logic wr_fire, cmd_init, precnt_ovf, timeout_now;
  logic osc_enable, osc_ready, osc_tick;

  tdcc_fast_osc #(
    .SETTLE_A(SETTLE_A),
    .SETTLE_B(SETTLE_B),
    .SETTLE_C(SETTLE_C),
    .SETTLE_D(SETTLE_D)
  ) u_fast_osc (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .soft_rst(por_q),
    .fast_oscillator_clock(fast_oscillator_clock),
    .fast_osc_predivider(cfg_q.fast_osc_predivider),
    .fast_osc_start_option(cfg_q.fast_osc_start_option),
    .run_req(run_q),
    .osc_enable(osc_enable),
    .osc_ready(osc_ready),
    .osc_tick(osc_tick)
  );

  // One transaction per channel in flight; response blocks new addresses
  assign s_axi_awready = !aw_vld_q && !b_vld_q;
  assign s_axi_wready = !w_vld_q && !b_vld_q;
  assign s_axi_arready = !r_vld_q;
  assign wr_fire = aw_vld_q && w_vld_q && !b_vld_q;

  // Precounter overflow only counts in mode two while the core measures
  assign precnt_ovf = cfg_q.measure_mode2 && core_evt.meas_active && osc_tick && (precnt_q == PRECNT_MAX);
  assign timeout_now = stat_q.tdc_timeout_flag || stat_q.precounter_timeout_flag ||
                       (core_evt.tdc_overflow && !core_evt.meas_done) || precnt_ovf;

  // Bus slave, configuration, commands and sticky status
  always_comb begin
    aw_vld_d = aw_vld_q;
    aw_addr_d = aw_addr_q;
    w_vld_d = w_vld_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    b_vld_d = b_vld_q;
    b_resp_d = b_resp_q;
    r_vld_d = r_vld_q;
    r_data_d = r_data_q;
    r_resp_d = r_resp_q;
    cfg_d = cfg_q;
    por_d = 1'b0;
    cmd_init = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_vld_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_vld_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_vld_d = 1'b0;
      w_vld_d = 1'b0;
      b_vld_d = 1'b1;
      b_resp_d = RESP_OKAY;
      case (reg_sel(aw_addr_q))
        SEL_CONFIG: cfg_d = merge_bytes(cfg_q, w_data_q, w_strb_q) & CFG_WMASK;
        SEL_COMMAND: begin
          if (w_strb_q[0] && w_data_q[7:0] == OPC_POWER_ON_RESET) begin
            por_d = 1'b1; // RQ19
          end else if (w_strb_q[0] && w_data_q[7:0] == OPC_INIT) begin
            cmd_init = 1'b1; // RQ20
          end else begin
            b_resp_d = RESP_SLVERR;
          end
        end
        SEL_STATUS, SEL_RESULT: b_resp_d = RESP_OKAY;
        default: b_resp_d = RESP_SLVERR;
      endcase
    end
    if (s_axi_bvalid && s_axi_bready) begin
      b_vld_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      r_vld_d = 1'b1;
      r_resp_d = RESP_OKAY;
      case (reg_sel(s_axi_araddr))
        SEL_CONFIG: r_data_d = cfg_q;
        SEL_STATUS: r_data_d = stat_q; // RQ18
        SEL_RESULT: r_data_d = result_q;
        SEL_COMMAND: r_data_d = '0;
        default: begin
          r_data_d = '0;
          r_resp_d = RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      r_vld_d = 1'b0;
    end
    // Init from the bus or after an interrupt when auto re-init is on
    init_d = cmd_init || (core_evt.core_irq && cfg_q.auto_reinit_enable); // RQ13
    run_d = (run_q && !core_evt.core_irq) || init_q;
    // Sticky flags: an event in the clearing cycle survives
    stat_d = stat_q;
    if (init_q) begin
      stat_d.nvm_uncorrectable_flag = 1'b0;
      stat_d.nvm_corrected_flag = 1'b0;
      stat_d.sensor_short_flag = 1'b0;
      stat_d.sensor_open_flag = 1'b0;
      stat_d.precounter_timeout_flag = 1'b0;
      stat_d.tdc_timeout_flag = 1'b0;
    end
    stat_d.nvm_uncorrectable_flag = stat_d.nvm_uncorrectable_flag | core_evt.nvm_double_err; // RQ2
    stat_d.nvm_corrected_flag = stat_d.nvm_corrected_flag | core_evt.nvm_single_err; // RQ3
    stat_d.sensor_short_flag = stat_d.sensor_short_flag | core_evt.sensor_short; // RQ4
    stat_d.sensor_open_flag = stat_d.sensor_open_flag | core_evt.sensor_open; // RQ5
    stat_d.precounter_timeout_flag = stat_d.precounter_timeout_flag | precnt_ovf; // RQ6
    stat_d.tdc_timeout_flag = stat_d.tdc_timeout_flag | (core_evt.tdc_overflow && !core_evt.meas_done); // RQ7
    stat_d.config_matches_nvm_flag = (cfg_q == nvm_config); // RQ1
    stat_d.fast_osc_ready = osc_ready;
    stat_d.rsvd = '0;
    // Precounter restarts with every measurement
    if (!core_evt.meas_active || init_q) begin
      precnt_d = '0;
    end else if (osc_tick) begin
      precnt_d = precnt_q + 1'b1; // RQ6
    end else begin
      precnt_d = precnt_q;
    end
    // Error pattern replaces a timed-out result
    result_d = result_q;
    if (core_evt.result_valid) begin
      result_d = (cfg_q.timeout_error_value_enable && timeout_now) ? ERR_VALUE : core_result; // RQ14
    end
    if (por_q) begin
      cfg_d = CFG_RESET; // RQ19
      stat_d = '0;
      result_d = '0;
      precnt_d = '0;
      run_d = 1'b0;
      init_d = 1'b0;
    end
  end

  // Outputs to the core are registered so they do not glitch
  always_comb begin
    ctrl_d.fast_osc_enable = osc_enable; // RQ9
    ctrl_d.fast_osc_ready = osc_ready;
    ctrl_d.fast_osc_tick = osc_tick; // RQ8
    ctrl_d.osc32_low_current = cfg_q.osc32_low_current; // RQ10
    ctrl_d.start_noise_enable = cfg_q.start_noise_enable; // RQ11
    ctrl_d.phase_noise_disable = cfg_q.phase_noise_disable; // RQ12
    ctrl_d.twofold_resolution_mode = cfg_q.twofold_resolution_mode; // RQ16
    // A fourfold request in mode one is held off, not passed to the core
    ctrl_d.fourfold_resolution_mode = cfg_q.fourfold_resolution_mode && cfg_q.measure_mode2; // RQ15
    ctrl_d.measure_mode2 = cfg_q.measure_mode2;
    ctrl_d.init_pulse = init_q; // RQ20
    ctrl_d.por_pulse = por_q; // RQ19
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      aw_vld_q <= 1'b0;
      aw_addr_q <= '0;
      w_vld_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      b_vld_q <= 1'b0;
      b_resp_q <= RESP_OKAY;
      r_vld_q <= 1'b0;
      r_data_q <= '0;
      r_resp_q <= RESP_OKAY;
      cfg_q <= CFG_RESET;
      stat_q <= '0;
      ctrl_q <= '0;
      precnt_q <= '0;
      result_q <= '0;
      init_q <= 1'b0;
      por_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      aw_vld_q <= aw_vld_d;
      aw_addr_q <= aw_addr_d;
      w_vld_q <= w_vld_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      b_vld_q <= b_vld_d;
      b_resp_q <= b_resp_d;
      r_vld_q <= r_vld_d;
      r_data_q <= r_data_d;
      r_resp_q <= r_resp_d;
      cfg_q <= cfg_d;
      stat_q <= stat_d;
      ctrl_q <= ctrl_d;
      precnt_q <= precnt_d;
      result_q <= result_d;
      init_q <= init_d;
      por_q <= por_d;
      run_q <= run_d;
    end
  end

  assign s_axi_bvalid = b_vld_q;
  assign s_axi_bresp = b_resp_q;
  assign s_axi_rvalid = r_vld_q;
  assign s_axi_rdata = r_data_q;
  assign s_axi_rresp = r_resp_q;
  assign core_ctrl = ctrl_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_match;
    (!por_q && cfg_q == nvm_config) |=> stat_q.config_matches_nvm_flag;
  endproperty
  a_match: assert property (p_match) else $error("match flag missing"); // RQ1

  property p_dbl;
    (core_evt.nvm_double_err && !por_q) |=> stat_q.nvm_uncorrectable_flag;
  endproperty
  a_dbl: assert property (p_dbl) else $error("uncorrectable flag not set"); // RQ2

  property p_sgl;
    (core_evt.nvm_single_err && !por_q) |=> stat_q.nvm_corrected_flag;
  endproperty
  a_sgl: assert property (p_sgl) else $error("corrected flag not set"); // RQ3

  property p_short;
    (core_evt.sensor_short && !por_q) |=> stat_q.sensor_short_flag;
  endproperty
  a_short: assert property (p_short) else $error("short flag not set"); // RQ4

  property p_open;
    (core_evt.sensor_open && !por_q) |=> stat_q.sensor_open_flag;
  endproperty
  a_open: assert property (p_open) else $error("open flag not set"); // RQ5

  property p_precnt;
    (precnt_ovf && !por_q) |=> stat_q.precounter_timeout_flag && precnt_q == '0;
  endproperty
  a_precnt: assert property (p_precnt) else $error("precounter overflow lost"); // RQ6

  property p_tdc;
    (core_evt.tdc_overflow && !core_evt.meas_done && !por_q) |=> stat_q.tdc_timeout_flag;
  endproperty
  a_tdc: assert property (p_tdc) else $error("converter timeout lost"); // RQ7

  property p_errval;
    (core_evt.result_valid && cfg_q.timeout_error_value_enable && timeout_now && !por_q) |=> result_q == ERR_VALUE;
  endproperty
  a_errval: assert property (p_errval) else $error("error value not written"); // RQ14

  property p_quad;
    core_ctrl.fourfold_resolution_mode |-> $past(cfg_q.measure_mode2);
  endproperty
  a_quad: assert property (p_quad) else $error("fourfold outside mode two"); // RQ15

  property p_reinit;
    (core_evt.core_irq && cfg_q.auto_reinit_enable && !por_q) |=> ##1 core_ctrl.init_pulse;
  endproperty
  a_reinit: assert property (p_reinit) else $error("auto re-init missing"); // RQ13

  property p_init_keeps;
    (cmd_init && !(s_axi_awvalid || s_axi_wvalid)) |=> cfg_q == $past(cfg_q) ##1 core_ctrl.init_pulse;
  endproperty
  a_init_keeps: assert property (p_init_keeps) else $error("init altered configuration"); // RQ20

  property p_por;
    por_q |=> cfg_q == CFG_RESET && stat_q.tdc_timeout_flag == 1'b0;
  endproperty
  a_por: assert property (p_por) else $error("power-on reset incomplete"); // RQ19

endmodule

// ===== tdcc_core_model.sv
// Purpose: Stand-in for the measurement core and the fast oscillator pin
// Assumes: Event requests change just after clk_sys rising edges
// Notes: Oscillator runs free at 1.25 MHz, well under the sync limit
`timescale 1ns/1ps
module tdcc_core_model import tdcc_pkg::*; #(
  parameter logic [31:0] RESULT_WORD = 32'h00012345
) (
  input wire logic clk_sys,
  input wire tdcc_evt_t evt_req,
  output tdcc_evt_t core_evt,
  output logic [31:0] core_result,
  output logic fast_oscillator_clock
);
  // Free-running oscillator, eight system cycles per period
  initial fast_oscillator_clock = 1'b0;
  always #400 fast_oscillator_clock = ~fast_oscillator_clock;
  // Result word is only good with its strobe, so it churns otherwise
  initial core_result = 32'h0;
  always @(posedge clk_sys) begin
    core_evt <= evt_req;
    core_result <= evt_req.result_valid ? RESULT_WORD : ~core_result;
  end
endmodule

// ===== test_tdc_config_status_control.sv
// Purpose: Self-checking bench for the converter control bank
// Assumes: AXI4-Lite master tasks, core events through the core model
// Notes: Small settling counts so the slowest start option settles within a few reads
`timescale 1ns/1ps
module test_tdc_config_status_control import tdcc_pkg::*;;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, nvm_config = 32'h0, rd, rdata, core_result;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, osc;
  logic [1:0] bresp, rresp, resp;
  tdcc_evt_t evt_req = 9'h000, core_evt;
  tdcc_ctrl_t core_ctrl;
  int miscompares = 0, n_tests = 0, cycles = 0, ticks = 0, inits = 0, pors = 0, t0;
  always #50 clk_sys = ~clk_sys;
  tdcc_core_model core (.clk_sys(clk_sys), .evt_req(evt_req), .core_evt(core_evt),
    .core_result(core_result), .fast_oscillator_clock(osc));
  tdcc_regs #(.SETTLE_A(4), .SETTLE_B(5), .SETTLE_C(6), .SETTLE_D(7)) dut (.clk_sys(clk_sys), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .fast_oscillator_clock(osc), .core_evt(core_evt), .core_result(core_result),
    .nvm_config(nvm_config), .core_ctrl(core_ctrl));
  // Watchdog, plus counts of divided oscillator ticks and core strobes
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (core_ctrl.fast_osc_tick === 1'b1) ticks <= ticks + 1;
    if (core_ctrl.init_pulse === 1'b1) inits <= inits + 1;
    if (core_ctrl.por_pulse === 1'b1) pors <= pors + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Handshakes are judged at the falling edge, where nothing moves
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    bh = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bh) begin
      @(negedge clk_sys);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid && bready;
      resp = bresp;
      @(posedge clk_sys);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic axr(input logic [7:0] a);
    logic ah, hs;
    hs = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hs) begin
      @(negedge clk_sys);
      ah = arvalid && arready;
      hs = rvalid && rready;
      rd = rdata;
      resp = rresp;
      @(posedge clk_sys);
      if (ah) arvalid <= 1'b0;
      if (hs) rready <= 1'b0;
    end
  endtask
  // One-cycle event from the core, then time for the sticky flag
  task automatic pulse(input tdcc_evt_t e);
    @(posedge clk_sys);
    evt_req <= e;
    @(posedge clk_sys);
    evt_req <= 9'h000;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    axr(OFS_CONFIG);
    chk(rd, CFG_RESET);
    axr(8'h10);
    chk(32'(resp), 32'(RESP_SLVERR));
    chk(rd, 32'h0);
    // Host bring-up order: reset, configuration, init
    axw(OFS_COMMAND, 32'h00000050);
    axw(OFS_CONFIG, 32'hFFFF0CE5);
    axw(OFS_COMMAND, 32'h00000070);
    axr(OFS_CONFIG);
    chk(rd, 32'h00000CE5);
    chk(32'({core_ctrl.fourfold_resolution_mode, core_ctrl.twofold_resolution_mode, core_ctrl.start_noise_enable,
      core_ctrl.phase_noise_disable, core_ctrl.osc32_low_current}), 32'h0000000F);
    axw(OFS_CONFIG, 32'h00001CE5);
    nvm_config <= 32'h00001CE5;
    chk(32'({core_ctrl.fourfold_resolution_mode, core_ctrl.measure_mode2}), 32'h3);
    // Every core error event at once, then one status read
    pulse(9'h1F0);
    axr(OFS_STATUS);
    chk(rd, 32'h000000DF);
    axw(OFS_COMMAND, 32'h00000070);
    axr(OFS_STATUS);
    chk(rd, 32'h00000081);
    axr(OFS_CONFIG);
    chk(rd, 32'h00001CE5);
    axw(OFS_CONFIG, 32'h00001EE5);
    pulse(9'h001);
    axr(OFS_RESULT);
    chk(rd, 32'h00012345);
    pulse(9'h011);
    axr(OFS_RESULT);
    chk(rd, ERR_VALUE);
    axw(OFS_CONFIG, 32'h00001FE5);
    pulse(9'h040);
    axr(OFS_STATUS);
    chk(rd, 32'h000000C8);
    pulse(9'h004);
    axr(OFS_STATUS);
    chk(rd, 32'h00000080);
    axw(OFS_COMMAND, 32'h00000033);
    chk(32'(resp), 32'(RESP_SLVERR));
    axw(8'h20, 32'h0);
    chk(32'(resp), 32'(RESP_SLVERR));
    // 640 cycles hold 80 pin periods; sync jitter allows one tick either way
    for (int c = 0; c < 3; c++) begin
      axw(OFS_CONFIG, 32'h00000024 | c);
      t0 = ticks;
      repeat (640) @(posedge clk_sys);
      chk(32'((ticks - t0) >= (80 >> c) - 1 && (ticks - t0) <= (80 >> c) + 1), 32'h1);
    end
    axw(OFS_COMMAND, 32'h00000050);
    axr(OFS_CONFIG);
    chk(rd, CFG_RESET);
    // Low byte only: slowest settling option, oscillator stays off until init arms it
    wstrb <= 4'h1;
    axw(OFS_CONFIG, 32'hFFFFFF34);
    wstrb <= 4'hF;
    axr(OFS_CONFIG);
    chk(rd, 32'h00000034);
    chk(32'(core_ctrl.fast_osc_enable), 32'h0);
    axw(OFS_COMMAND, 32'h00000070);
    axr(OFS_STATUS);
    chk(rd, 32'h00000000);
    repeat (10) @(posedge clk_sys);
    axr(OFS_STATUS);
    chk(rd, 32'h00000080);
    chk(32'({core_ctrl.fast_osc_enable, core_ctrl.fast_osc_ready}), 32'h3);
    chk(32'(inits), 32'h4);
    chk(32'(pors), 32'h2);
    close_out();
  end
endmodule
